// [pkg/lsl_pkg.sv]
// Shared constants and types for the limit-security command link
// What this block does
// - Feature 01h/02h/03h selects store, lock, unlock
// - All subcommands use command opcode F9h
// - F9h after native-max read means limit setting
// - Password store moves exactly one data sector
// - Sector word 0 reserved, 1-16 password
// - Password lives only until power cycle
// - Accepted password store leaves device unlocked
// - Lock rejects all F9h commands but unlock and freeze
// - Locked until reset, unlock or freeze
// - Unlock receives sector, compares stored password
// - Mismatch aborts and decrements attempt counter
// - Attempt counter starts at five, drops per miss
// - Counter at zero rejects every unlock
// - Matching unlock returns device to unlocked
// - Feature 04h freezes; later limit commands rejected
// - Locked or frozen aborts limit-setting commands
`default_nettype none

package lsl_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_LIMIT = 8'hF9;
  localparam logic [7:0] CMD_READ_NATIVE = 8'hF8;
  localparam logic [7:0] FEAT_PWSET = 8'h01;
  localparam logic [7:0] FEAT_LOCK = 8'h02;
  localparam logic [7:0] FEAT_UNLOCK = 8'h03;
  localparam logic [7:0] FEAT_FREEZE = 8'h04;

  // ----------------------------------------------------------------
  // Sector layout and counts
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam int unsigned PW_WORDS = 16;
  localparam logic [8:0] PW_FIRST = 9'h001;
  localparam logic [8:0] PW_LAST = 9'h010;
  localparam logic [8:0] SECTOR_LAST = 9'h0FF;
  localparam logic [2:0] ATTEMPTS_INIT = 3'h5;

  // ----------------------------------------------------------------
  // Status and error register fields
  // ----------------------------------------------------------------
  localparam int unsigned ST_BSY = 7;
  localparam int unsigned ST_RDY = 6;
  localparam int unsigned ST_DRQ = 3;
  localparam int unsigned ST_ERR = 0;
  localparam int unsigned ER_ABT = 2;
  localparam logic [7:0] STAT_OK = 8'h40;
  localparam logic [7:0] STAT_DRQ = 8'h48;
  localparam logic [7:0] STAT_FAIL = 8'h41;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_ABORT = 8'h04;

  // ----------------------------------------------------------------
  // Host controller register map
  // ----------------------------------------------------------------
  localparam logic [7:0] HREG_CTRL = 8'h00;
  localparam logic [7:0] HREG_STAT = 8'h04;
  localparam logic [3:0] HREG_PW_HI = 4'h1;

  typedef enum logic [1:0] {SEC_UNLOCKED, SEC_LOCKED, SEC_FROZEN} lsl_sec_t;
  typedef enum logic {DST_IDLE, DST_XFER} lsl_dstate_t;
  typedef enum logic {OP_PWSET, OP_UNLOCK} lsl_op_t;
  typedef enum logic [1:0] {HST_IDLE, HST_WAIT, HST_SEND, HST_TAIL} lsl_hstate_t;

endpackage : lsl_pkg

`default_nettype wire

// [pkg/lsl_link_if.sv]
// Command, data and status link between host controller and device
`default_nettype none

interface lsl_link_if;
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic [7:0] cmd_feature;
  logic wr_valid;
  logic [15:0] wr_word;
  logic [7:0] status;
  logic [7:0] error;
  logic done;

  modport host (
    output cmd_valid, cmd_code, cmd_feature, wr_valid, wr_word,
    input status, error, done
  );
  modport dev (
    input cmd_valid, cmd_code, cmd_feature, wr_valid, wr_word,
    output status, error, done
  );
endinterface : lsl_link_if

`default_nettype wire

// [rtl/lsl_pw_slot.sv]
// Volatile password word store with per-word compare
`default_nettype none

module lsl_pw_slot #(
  parameter int unsigned WORDS = 16,
  parameter int unsigned W = 16
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic [$clog2(WORDS)-1:0] i_index,
  input wire logic [W-1:0] i_word,
  output logic o_match
);

  localparam int IW = $clog2(WORDS);

  logic [W-1:0] slot [WORDS];

  // ----------------------------------------------------------------
  // Storage, cleared by every reset
  // ----------------------------------------------------------------
  for (genvar g = 0; g < WORDS; g++) begin : g_word
    always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
        slot[g] <= '0;
      end else if (i_wr && i_index == IW'(g)) begin
        slot[g] <= i_word;
      end
    end
  end

  assign o_match = (slot[i_index] == i_word);

endmodule // lsl_pw_slot

`default_nettype wire

// [rtl/lsl_device.sv]
// Device end: limit-security command interpreter
`default_nettype none

module lsl_device #(
  parameter logic [2:0] ATTEMPTS_INIT = lsl_pkg::ATTEMPTS_INIT
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  lsl_link_if.dev link,
  output logic [1:0] o_sec_state,
  output logic [2:0] o_attempts
);

  // Security state, sequencer and reported registers
  lsl_pkg::lsl_sec_t sec;
  lsl_pkg::lsl_dstate_t state;
  lsl_pkg::lsl_op_t op;
  logic [2:0] attempts;
  logic [8:0] word_cnt;
  logic native_seen;
  logic mism;
  logic [7:0] status;
  logic [7:0] error;
  logic done;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire logic cmd_take = (state == lsl_pkg::DST_IDLE) && link.cmd_valid;
  wire logic is_limit = (link.cmd_code == lsl_pkg::CMD_LIMIT);
  wire logic is_native = (link.cmd_code == lsl_pkg::CMD_READ_NATIVE);
  // Pairing holds only for the command taken right after F8h
  wire logic as_setmax = is_limit && native_seen;
  wire logic [7:0] feat = link.cmd_feature;
  wire logic f_pwset = (feat == lsl_pkg::FEAT_PWSET);
  wire logic f_lock = (feat == lsl_pkg::FEAT_LOCK);
  wire logic f_unlock = (feat == lsl_pkg::FEAT_UNLOCK);
  wire logic f_freeze = (feat == lsl_pkg::FEAT_FREEZE);
  wire logic frozen = (sec == lsl_pkg::SEC_FROZEN);
  wire logic guarded = (sec != lsl_pkg::SEC_UNLOCKED);
  wire logic no_tries = (attempts == 3'h0);


  // ----------------------------------------------------------------
  // Subcommand refusal
  // ----------------------------------------------------------------
  // Store and lock need the open state; lock while locked is refused
  wire logic rej_store_lock = (f_pwset || f_lock) && guarded;
  // Unlock stays possible while locked, until tries run out
  wire logic rej_unlock = f_unlock && (frozen || no_tries);
  wire logic rej_freeze = f_freeze && frozen;
  // Unknown feature codes are refused as well
  wire logic f_known = f_pwset || f_lock || f_unlock || f_freeze;
  wire logic rej_sub = !f_known || rej_store_lock || rej_unlock || rej_freeze;

  // ----------------------------------------------------------------
  // Command acceptance
  // ----------------------------------------------------------------
  wire logic reject = as_setmax ? guarded : rej_sub;
  wire logic rej_cmd = is_limit && reject;
  wire logic sub_ok = is_limit && !as_setmax && !reject;
  wire logic needs_data = sub_ok && (f_pwset || f_unlock);

  // ----------------------------------------------------------------
  // Sector transfer
  // ----------------------------------------------------------------
  wire logic xfer_word = (state == lsl_pkg::DST_XFER) && link.wr_valid;
  wire logic last_word = (word_cnt == lsl_pkg::SECTOR_LAST);
  wire logic finish = xfer_word && last_word;
  // Reserved words are counted but neither stored nor compared
  wire logic in_pw = (word_cnt >= lsl_pkg::PW_FIRST) && (word_cnt <= lsl_pkg::PW_LAST);
  wire logic [8:0] pw_off = word_cnt - lsl_pkg::PW_FIRST;
  wire logic [3:0] pw_index = pw_off[3:0];
  wire logic slot_wr = xfer_word && in_pw && (op == lsl_pkg::OP_PWSET);
  wire logic slot_match;
  // Compare is on the word as it arrives, so no sector buffer
  wire logic word_bad = in_pw && !slot_match;
  wire logic final_bad = mism || word_bad;
  // Verdict only at the last word; a store never aborts
  wire logic abort_fin = (op == lsl_pkg::OP_UNLOCK) && final_bad;
  // Cannot wrap: unlock is refused once the count is zero
  wire logic [2:0] next_attempts = attempts - 3'h1;

  // Store writes during the transfer; the command is already accepted
  lsl_pw_slot #(
    .WORDS(lsl_pkg::PW_WORDS),
    .W(lsl_pkg::WORD_W)
  ) u_slot (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_wr(slot_wr),
    .i_index(pw_index),
    .i_word(link.wr_word),
    .o_match(slot_match)
  );

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  // Counts the whole sector; new commands are ignored until it ends
  // Host always sends all words, so a cut sector is not handled
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state <= lsl_pkg::DST_IDLE;
      op <= lsl_pkg::OP_PWSET;
      word_cnt <= 9'h000;
    end else if (cmd_take && needs_data) begin
      state <= lsl_pkg::DST_XFER;
      op <= f_unlock ? lsl_pkg::OP_UNLOCK : lsl_pkg::OP_PWSET;
      word_cnt <= 9'h000;
    end else if (xfer_word) begin
      word_cnt <= word_cnt + 9'h001;
      if (last_word) begin
        state <= lsl_pkg::DST_IDLE;
      end
    end
  end

  // Mismatch is sticky across the sixteen password words
  // Cleared per command so an old miss never taints the next
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      mism <= 1'b0;
    end else if (cmd_take) begin
      mism <= 1'b0;
    end else if (xfer_word) begin
      mism <= final_bad;
    end
  end

  // Any other command breaks the native-max pairing
  // Only taken commands count, so a refused one breaks it too
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      native_seen <= 1'b0;
    end else if (cmd_take) begin
      native_seen <= is_native;
    end
  end

  // ----------------------------------------------------------------
  // Security state and attempt counter
  // ----------------------------------------------------------------
  // Lock and freeze act at the take; store and unlock at the last word
  // A refused command reaches none of these branches
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sec <= lsl_pkg::SEC_UNLOCKED;
    end else if (cmd_take && sub_ok && f_lock) begin
      sec <= lsl_pkg::SEC_LOCKED;
    end else if (cmd_take && sub_ok && f_freeze) begin
      sec <= lsl_pkg::SEC_FROZEN;
    end else if (finish && !abort_fin) begin
      sec <= lsl_pkg::SEC_UNLOCKED;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      attempts <= ATTEMPTS_INIT;
    end else if (finish && abort_fin) begin
      attempts <= next_attempts;
    end
  end

  // ----------------------------------------------------------------
  // Status and error reporting
  // ----------------------------------------------------------------
  // Non-data commands complete in one cycle; BSY is never set, even during a transfer
  // Status and error stand until the next command changes them
  // Done is a single-cycle pulse; the host latches the pair then
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      status <= lsl_pkg::STAT_OK;
      error <= lsl_pkg::ERR_NONE;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (cmd_take && needs_data) begin
        status <= lsl_pkg::STAT_DRQ;
        error <= lsl_pkg::ERR_NONE;
      end else if (cmd_take) begin
        status <= rej_cmd ? lsl_pkg::STAT_FAIL : lsl_pkg::STAT_OK;
        error <= rej_cmd ? lsl_pkg::ERR_ABORT : lsl_pkg::ERR_NONE;
        done <= 1'b1;
      end else if (finish) begin
        status <= abort_fin ? lsl_pkg::STAT_FAIL : lsl_pkg::STAT_OK;
        error <= abort_fin ? lsl_pkg::ERR_ABORT : lsl_pkg::ERR_NONE;
        done <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  assign link.status = status;
  assign link.error = error;
  assign link.done = done;
  assign o_sec_state = sec;
  assign o_attempts = attempts;

endmodule // lsl_device

`default_nettype wire

// [rtl/lsl_host.sv]
// Host end: register-driven controller issuing limit-security commands
`default_nettype none

module lsl_host (
  input wire logic i_clock,
  input wire logic i_rst_n,
  lsl_link_if.host link,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata
);

  lsl_pkg::lsl_hstate_t state;
  logic [15:0] pw [lsl_pkg::PW_WORDS];
  logic [8:0] cnt;
  logic [7:0] last_status;
  logic [7:0] last_error;
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic [7:0] cmd_feature;
  logic wr_valid;
  logic [15:0] wr_word;
  logic [31:0] rdata;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire logic busy = (state != lsl_pkg::HST_IDLE);
  wire logic ctrl_wr = i_wr && (i_addr == lsl_pkg::HREG_CTRL) && !busy;
  wire logic pw_hit = (i_addr[7:4] == lsl_pkg::HREG_PW_HI);
  wire logic [31:0] stat_word = {15'h0000, busy, last_error, last_status};
  wire logic [31:0] rd_mux = (i_addr == lsl_pkg::HREG_STAT) ? stat_word :
                             pw_hit ? {16'h0000, pw[i_addr[3:0]]} : 32'h0000_0000;
  wire logic in_pw = (cnt >= lsl_pkg::PW_FIRST) && (cnt <= lsl_pkg::PW_LAST);
  wire logic [8:0] pw_off = cnt - lsl_pkg::PW_FIRST;
  wire logic [15:0] out_word = in_pw ? pw[pw_off[3:0]] : 16'h0000;

  // Password kept in host flops for the payload sector
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pw <= '{default: 16'h0000};
    end else if (i_wr && pw_hit) begin
      pw[i_addr[3:0]] <= i_wdata[15:0];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= i_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state <= lsl_pkg::HST_IDLE;
      cmd_valid <= 1'b0;
      cmd_code <= 8'h00;
      cmd_feature <= 8'h00;
      wr_valid <= 1'b0;
      wr_word <= 16'h0000;
      cnt <= 9'h000;
      last_status <= lsl_pkg::STAT_OK;
      last_error <= lsl_pkg::ERR_NONE;
    end else begin
      cmd_valid <= 1'b0;
      wr_valid <= 1'b0;
      unique case (state)
        lsl_pkg::HST_IDLE: begin
          if (ctrl_wr) begin
            cmd_valid <= 1'b1;
            cmd_code <= i_wdata[7:0];
            cmd_feature <= i_wdata[15:8];
            state <= lsl_pkg::HST_WAIT;
          end
        end
        lsl_pkg::HST_WAIT: begin
          if (link.done) begin
            last_status <= link.status;
            last_error <= link.error;
            state <= lsl_pkg::HST_IDLE;
          end else if (link.status[lsl_pkg::ST_DRQ]) begin
            cnt <= 9'h000;
            state <= lsl_pkg::HST_SEND;
          end
        end
        lsl_pkg::HST_SEND: begin
          wr_valid <= 1'b1;
          wr_word <= out_word;
          cnt <= cnt + 9'h001;
          // Exactly one sector, even though DRQ lags the last word
          if (cnt == lsl_pkg::SECTOR_LAST) begin
            state <= lsl_pkg::HST_TAIL;
          end
        end
        lsl_pkg::HST_TAIL: begin
          if (link.done) begin
            last_status <= link.status;
            last_error <= link.error;
            state <= lsl_pkg::HST_IDLE;
          end
        end
      endcase
    end
  end

  assign link.cmd_valid = cmd_valid;
  assign link.cmd_code = cmd_code;
  assign link.cmd_feature = cmd_feature;
  assign link.wr_valid = wr_valid;
  assign link.wr_word = wr_word;
  assign o_rdata = rdata;

endmodule // lsl_host

`default_nettype wire

// [tb/lsl_link_asserts.sv]
// Concurrent checks on the host-device limit-security link
`default_nettype none

module lsl_link_asserts (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_feature,
  input wire logic wr_valid,
  input wire logic [15:0] wr_word,
  input wire logic [7:0] status,
  input wire logic [7:0] error,
  input wire logic done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic prev_native;
  logic [8:0] wcnt;
  wire drq = status[lsl_pkg::ST_DRQ];
  wire take = cmd_valid && !drq;
  wire data_feat = cmd_feature == lsl_pkg::FEAT_PWSET || cmd_feature == lsl_pkg::FEAT_UNLOCK;
  wire is_data = take && cmd_code == lsl_pkg::CMD_LIMIT && !prev_native && data_feat;

  // Pairing only looks at the last taken command
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      prev_native <= 1'b0;
    end else if (take) begin
      prev_native <= cmd_code == lsl_pkg::CMD_READ_NATIVE;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || cmd_valid) begin
      wcnt <= 9'h000;
    end else if (wr_valid && drq) begin
      wcnt <= wcnt + 9'h001;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  a_done_single: assert property (done |=> !done)
    else $error("done lasted more than one cycle");
  a_status_bits: assert property (!status[7] && status[6])
    else $error("busy set or ready clear");
  a_abort_code: assert property (done && error == lsl_pkg::ERR_ABORT |-> status == lsl_pkg::STAT_FAIL)
    else $error("abort without error status");
  a_ok_clean: assert property (done && !status[0] |-> error == lsl_pkg::ERR_NONE)
    else $error("good completion with error bits");
  a_cmd_answer: assert property (take && !is_data |=> done && !drq)
    else $error("non-data command not answered next cycle");
  a_data_req: assert property (is_data |=> status == lsl_pkg::STAT_DRQ || (done && status[0]))
    else $error("data subcommand neither requested data nor aborted");
  a_sector_len: assert property ($fell(drq) |-> done && wcnt == 9'h100)
    else $error("transfer did not end after one sector");
  a_drq_holds: assert property (drq && !(wr_valid && wcnt == 9'h0FF) |=> drq)
    else $error("data request dropped early");
  a_drq_no_done: assert property (drq |-> !done)
    else $error("done during data transfer");

  c_abort: cover property (done && status == lsl_pkg::STAT_FAIL);
  c_sector: cover property ($fell(drq));
  c_pair: cover property (take && prev_native && cmd_code == lsl_pkg::CMD_LIMIT);

endmodule // lsl_link_asserts

`default_nettype wire

// [tb/tb_max_address_security_lock.sv]
// Testbench: host and device joined over the link, driven through host registers
`default_nettype none

module tb_max_address_security_lock;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic rd_q = 1'b0;
  logic [31:0] o_rdata;
  logic [1:0] o_sec_state;
  logic [2:0] o_attempts;
  logic [15:0] lfsr = 16'h22EF;
  logic [15:0] pw [16];
  logic [31:0] exp_q [$];
  int error_cnt = 0;
  int tests_run = 0;

  lsl_link_if link ();
  lsl_host lsl_host_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .link(link.host),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
  lsl_device lsl_device_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .link(link.dev),
    .o_sec_state(o_sec_state), .o_attempts(o_attempts));
  lsl_link_asserts lsl_link_asserts_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code), .cmd_feature(link.cmd_feature),
    .wr_valid(link.wr_valid), .wr_word(link.wr_word), .status(link.status),
    .error(link.error), .done(link.done));

  always #2 i_clock = ~i_clock;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wr <= wr;
    i_rd <= !wr;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  task automatic load_pw();
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, {lsl_pkg::HREG_PW_HI, 4'(i)}, {16'h0000, pw[i]});
    end
  endtask

  // Waits for the device's done, then reads back status and state
  task automatic run_cmd(input logic [7:0] code, input logic [7:0] feat, input logic ok,
                         input logic [1:0] sec, input logic [2:0] att);
    int n;
    bus(1'b1, lsl_pkg::HREG_CTRL, {16'h0000, feat, code});
    n = 0;
    while (link.done !== 1'b1 && n < 600) begin
      @(negedge i_clock);
      n++;
    end
    check({31'h0, link.done}, 32'h0000_0001);
    rd(lsl_pkg::HREG_STAT, {16'h0000, ok ? lsl_pkg::ERR_NONE : lsl_pkg::ERR_ABORT,
      ok ? lsl_pkg::STAT_OK : lsl_pkg::STAT_FAIL});
    check({30'h0, o_sec_state}, {30'h0, sec});
    check({29'h0, o_attempts}, {29'h0, att});
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge i_clock) rd_q <= i_rd;
  always @(negedge i_clock) if (rd_q) check(o_rdata, exp_q.pop_front());

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rd(lsl_pkg::HREG_STAT, 32'h0000_0040);
    rd(8'h80, 32'h0000_0000);
    check({29'h0, o_attempts}, 32'h0000_0005);
    for (int i = 0; i < 16; i++) begin
      pw[i] = lfsr;
      lfsr = lfsr_next(lfsr);
    end
    load_pw();
    run_cmd(lsl_pkg::CMD_LIMIT, lsl_pkg::FEAT_PWSET, 1'b1, 2'h0, 3'h5);
    run_cmd(lsl_pkg::CMD_LIMIT, lsl_pkg::FEAT_LOCK, 1'b1, 2'h1, 3'h5);
    run_cmd(lsl_pkg::CMD_LIMIT, lsl_pkg::FEAT_PWSET, 1'b0, 2'h1, 3'h5);
    run_cmd(lsl_pkg::CMD_LIMIT, lsl_pkg::FEAT_LOCK, 1'b0, 2'h1, 3'h5);
    run_cmd(lsl_pkg::CMD_READ_NATIVE, 8'h00, 1'b1, 2'h1, 3'h5);
    run_cmd(lsl_pkg::CMD_LIMIT, lsl_pkg::FEAT_UNLOCK, 1'b0, 2'h1, 3'h5);
    bus(1'b1, {lsl_pkg::HREG_PW_HI, 4'h0}, {16'h0000, ~pw[0]});
    run_cmd(lsl_pkg::CMD_LIMIT, lsl_pkg::FEAT_UNLOCK, 1'b0, 2'h1, 3'h4);
    load_pw();
    run_cmd(lsl_pkg::CMD_LIMIT, lsl_pkg::FEAT_UNLOCK, 1'b1, 2'h0, 3'h4);
    run_cmd(lsl_pkg::CMD_READ_NATIVE, 8'h00, 1'b1, 2'h0, 3'h4);
    run_cmd(lsl_pkg::CMD_LIMIT, lsl_pkg::FEAT_PWSET, 1'b1, 2'h0, 3'h4);
    run_cmd(lsl_pkg::CMD_LIMIT, lsl_pkg::FEAT_LOCK, 1'b1, 2'h1, 3'h4);
    // Last password word is the edge of the compared field
    bus(1'b1, {lsl_pkg::HREG_PW_HI, 4'hF}, {16'h0000, ~pw[15]});
    for (int k = 0; k < 4; k++) begin
      run_cmd(lsl_pkg::CMD_LIMIT, lsl_pkg::FEAT_UNLOCK, 1'b0, 2'h1, 3'(3 - k));
    end
    load_pw();
    run_cmd(lsl_pkg::CMD_LIMIT, lsl_pkg::FEAT_UNLOCK, 1'b0, 2'h1, 3'h0);
    run_cmd(lsl_pkg::CMD_LIMIT, 8'h05, 1'b0, 2'h1, 3'h0);
    run_cmd(lsl_pkg::CMD_LIMIT, lsl_pkg::FEAT_FREEZE, 1'b1, 2'h2, 3'h0);
    for (int f = 1; f < 5; f++) begin
      run_cmd(lsl_pkg::CMD_LIMIT, 8'(f), 1'b0, 2'h2, 3'h0);
    end
    // Reset stands for a power cycle: zero password must now match
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    check({30'h0, o_sec_state}, 32'h0000_0000);
    run_cmd(lsl_pkg::CMD_LIMIT, lsl_pkg::FEAT_UNLOCK, 1'b1, 2'h0, 3'h5);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge i_clock);
    error_cnt++;
    report_and_stop();
  end

endmodule // tb_max_address_security_lock

`default_nettype wire
